// [core/pcabt_top.sv]
// counter array time base: sfr registers, shared counter, flags, interrupt
`timescale 1ns/1ps
`include "pcabt_map.svh"
module pcabt_top (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic idle_mode_in,
   input wire logic timer0_ovf_in,
   input wire logic external_count_input_in,
   input wire logic fast_mixed_source_in,
   input wire logic master_divider_output_in,
   input wire logic toggle_pin_enable_in,
   input wire logic [5:0] module_event_in,
   input wire logic [5:0] module_irq_enable_in,
   input wire logic [5:0] module_buffer_mode_in,
   input wire logic [5:0] module_pin_use_in,
   output logic [7:0] sfr_rdata_out,
   output logic [15:0] count_value_out,
   output logic overflow_pulse_out,
   output logic overflow_toggle_out,
   output logic toggle_pin_out,
   output logic toggle_pin_oe_out,
   output logic [2:0] buffer_pair_active_out,
   output logic [5:0] gpio_release_out,
   output logic irq_out
);
   // register state
   pcabt_pkg::pcabt_byte_t ctrl_q;
   pcabt_pkg::pcabt_byte_t ctrl_d;
   pcabt_pkg::pcabt_byte_t mode_q;
   pcabt_pkg::pcabt_byte_t mode_d;
   pcabt_pkg::pcabt_byte_t reload_lo_q;
   pcabt_pkg::pcabt_byte_t reload_lo_d;
   pcabt_pkg::pcabt_byte_t reload_hi_q;
   pcabt_pkg::pcabt_byte_t reload_hi_d;
   pcabt_pkg::pcabt_count_t count_q;
   pcabt_pkg::pcabt_count_t count_d;
   logic toggle_q;
   logic toggle_d;
   pcabt_pkg::pcabt_byte_t rdata_d;
   pcabt_pkg::pcabt_byte_t read_value;
   logic irq_d;

   // decoded strobes
   logic wr_ctrl;
   logic wr_mode;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_rld_lo;
   logic wr_rld_hi;

   // control fields
   logic run;
   logic idle_gate;
   logic overflow_irq_enable;
   logic overflow_flag;
   logic [5:0] module_event_flag;
   logic [2:0] buffer_enable;
   logic [2:0] pair_ready;
   logic count_enable;
   logic at_max;
   logic overflow_event;
   pcabt_pkg::pcabt_byte_t ctrl_base;

   // link to the pulse generator
   pcabt_if pulse_link ();

   // address match used by every strobe
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] want);
      addr_hit = (addr == want);
   endfunction

   // read decode; unmapped sfr addresses return zero
   function automatic pcabt_pkg::pcabt_byte_t read_decode(
      input logic [7:0] addr,
      input pcabt_pkg::pcabt_byte_t ctrl,
      input pcabt_pkg::pcabt_byte_t mode,
      input pcabt_pkg::pcabt_count_t count,
      input pcabt_pkg::pcabt_byte_t rld_lo,
      input pcabt_pkg::pcabt_byte_t rld_hi
   );
      if (addr_hit(addr, `PCABT_ADDR_CTRL))
         read_decode = ctrl;
      else if (addr_hit(addr, `PCABT_ADDR_MODE))
         read_decode = mode;
      else if (addr_hit(addr, `PCABT_ADDR_CNT_LO))
         read_decode = count[`PCABT_BYTE_LO_MSB:`PCABT_BYTE_LO_LSB];
      else if (addr_hit(addr, `PCABT_ADDR_CNT_HI))
         read_decode = count[`PCABT_BYTE_HI_MSB:`PCABT_BYTE_HI_LSB];
      else if (addr_hit(addr, `PCABT_ADDR_RLD_LO))
         read_decode = rld_lo;
      else if (addr_hit(addr, `PCABT_ADDR_RLD_HI))
         read_decode = rld_hi;
      else
         read_decode = `PCABT_REG_RESET;
   endfunction

   // write strobes
   assign wr_ctrl = sfr_wr_in && addr_hit(sfr_addr_in, `PCABT_ADDR_CTRL);
   assign wr_mode = sfr_wr_in && addr_hit(sfr_addr_in, `PCABT_ADDR_MODE);
   assign wr_cnt_lo = sfr_wr_in && addr_hit(sfr_addr_in, `PCABT_ADDR_CNT_LO);
   assign wr_cnt_hi = sfr_wr_in && addr_hit(sfr_addr_in, `PCABT_ADDR_CNT_HI);
   assign wr_rld_lo = sfr_wr_in && addr_hit(sfr_addr_in, `PCABT_ADDR_RLD_LO);
   assign wr_rld_hi = sfr_wr_in && addr_hit(sfr_addr_in, `PCABT_ADDR_RLD_HI);

   // field views of the stored registers
   assign run = ctrl_q[`PCABT_CTRL_RUN_BIT];
   assign overflow_flag = ctrl_q[`PCABT_CTRL_OVF_BIT];
   assign module_event_flag = ctrl_q[`PCABT_CTRL_FLAG_MSB:`PCABT_CTRL_FLAG_LSB];
   assign idle_gate = mode_q[`PCABT_MODE_IDLE_BIT];
   assign overflow_irq_enable = mode_q[`PCABT_MODE_OVF_IE_BIT];
   assign buffer_enable = {mode_q[`PCABT_MODE_BUF4_BIT],
                           mode_q[`PCABT_MODE_BUF2_BIT],
                           mode_q[`PCABT_MODE_BUF0_BIT]};

   // pulse generator sees the source field and the timer 0 overflow
   assign pulse_link.source_select = mode_q[`PCABT_MODE_SRC_MSB:`PCABT_MODE_SRC_LSB];
   assign pulse_link.timer0_ovf = timer0_ovf_in;

   pcabt_pulse u_pulse (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .external_count_input_in(external_count_input_in),
      .fast_mixed_source_in(fast_mixed_source_in),
      .master_divider_output_in(master_divider_output_in),
      .link(pulse_link.gen)
   );

   // a step needs a pulse, the run bit, and no idle gating
   assign count_enable = pulse_link.count_tick && run
                         && !(idle_gate && idle_mode_in);
   assign at_max = (count_q == `PCABT_CNT_MAX);
   // a software write to either count byte wins over the step in that cycle
   assign overflow_event = count_enable && at_max && !wr_cnt_lo && !wr_cnt_hi;

   // counter next value: byte writes, reload on overflow, else increment
   always_comb
   begin
      count_d = count_q;
      if (wr_cnt_lo || wr_cnt_hi)
      begin
         if (wr_cnt_lo)
            count_d[`PCABT_BYTE_LO_MSB:`PCABT_BYTE_LO_LSB] = sfr_wdata_in;
         if (wr_cnt_hi)
            count_d[`PCABT_BYTE_HI_MSB:`PCABT_BYTE_HI_LSB] = sfr_wdata_in;
      end
      else if (overflow_event)
         count_d = {reload_hi_q, reload_lo_q};
      else if (count_enable)
         count_d = count_q + 16'h0001;
   end

   // control flags: the hardware set wins over a software clear in the same cycle
   assign ctrl_base = wr_ctrl ? sfr_wdata_in : ctrl_q;
   always_comb
   begin
      ctrl_d = ctrl_base;
      ctrl_d[`PCABT_CTRL_OVF_BIT] = ctrl_base[`PCABT_CTRL_OVF_BIT] | overflow_event;
      ctrl_d[`PCABT_CTRL_FLAG_MSB:`PCABT_CTRL_FLAG_LSB] =
         ctrl_base[`PCABT_CTRL_FLAG_MSB:`PCABT_CTRL_FLAG_LSB] | module_event_in;
   end

   // plain read/write registers
   assign mode_d = wr_mode ? sfr_wdata_in : mode_q;
   assign reload_lo_d = wr_rld_lo ? sfr_wdata_in : reload_lo_q;
   assign reload_hi_d = wr_rld_hi ? sfr_wdata_in : reload_hi_q;

   // overflow flips the toggle signal
   assign toggle_d = toggle_q ^ overflow_event;

   // buffering only counts when both modules of a pair are in a suitable mode
   genvar pair;
   generate
      for (pair = 0; pair < 3; pair++)
      begin : g_pair
         assign pair_ready[pair] = buffer_enable[pair]
                                   && module_buffer_mode_in[2*pair]
                                   && module_buffer_mode_in[2*pair+1];
      end
   endgenerate

   // combined request from stored flags, one cycle behind the flag itself
   assign irq_d = (overflow_flag && overflow_irq_enable)
                  || |(module_event_flag & module_irq_enable_in);

   // read data is captured on the read strobe and held until the next read
   assign read_value = read_decode(sfr_addr_in, ctrl_q, mode_q, count_q,
                                   reload_lo_q, reload_hi_q);
   assign rdata_d = sfr_rd_in ? read_value : sfr_rdata_out;

   // run bit and flags; the set-wins merge is done in ctrl_d,
   // so this flop only stores and the reset leaves the counter stopped
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         ctrl_q <= `PCABT_REG_RESET;
      else
         ctrl_q <= ctrl_d;
   end

   // mode register; a zero reset selects clk/12 with the idle gate open and every enable clear
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         mode_q <= `PCABT_REG_RESET;
      else
         mode_q <= mode_d;
   end

   // low reload byte
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         reload_lo_q <= `PCABT_REG_RESET;
      else
         reload_lo_q <= reload_lo_d;
   end

   // high reload byte
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         reload_hi_q <= `PCABT_REG_RESET;
      else
         reload_hi_q <= reload_hi_d;
   end

   // shared count; byte writes and reloads are already merged into count_d
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         count_q <= `PCABT_CNT_RESET;
      else
         count_q <= count_d;
   end

   // internal toggle level, flipped once per overflow
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         toggle_q <= 1'b0;
      else
         toggle_q <= toggle_d;
   end

   // read data register; without a read strobe it keeps the last answer
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         sfr_rdata_out <= `PCABT_REG_RESET;
      else
         sfr_rdata_out <= rdata_d;
   end

   // count bus and overflow pulse; the bus takes the next value so the modules
   // compare against the same number the counter holds, with no extra lag
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         count_value_out <= `PCABT_CNT_RESET;
         overflow_pulse_out <= 1'b0;
      end
      else
      begin
         count_value_out <= count_d;
         overflow_pulse_out <= overflow_event;
      end
   end

   // toggle output and its pin; the level runs on while the enable is low,
   // so enabling the pin later shows the true overflow parity at once
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         overflow_toggle_out <= 1'b0;
         toggle_pin_out <= 1'b0;
         toggle_pin_oe_out <= 1'b0;
      end
      else
      begin
         overflow_toggle_out <= toggle_d;
         toggle_pin_out <= toggle_d;
         toggle_pin_oe_out <= toggle_pin_enable_in;
      end
   end

   // module side views; every pin starts free for plain io
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         buffer_pair_active_out <= `PCABT_PAIR_RESET;
         gpio_release_out <= `PCABT_GPIO_RESET;
         irq_out <= 1'b0;
      end
      else
      begin
         buffer_pair_active_out <= pair_ready;
         gpio_release_out <= ~module_pin_use_in;
         irq_out <= irq_d;
      end
   end
endmodule // pcabt_top

// [core/pcabt_map.svh]
// register map, field positions and counts of the counter array time base
//
// Summary of operation
// - sixteen-bit up-counter of two bytes steps once per count pulse while running.
// - every counter overflow reloads both bytes from the two reload registers.
// - three-bit source field picks clk/12, clk/2, timer0, pin, fast, clk, master.
// - external source counts only falling transitions on the external count pin.
// - mode bit 0 decides whether the overflow flag requests an interrupt.
// - each overflow toggles a signal, driven on its pin only while enabled.
// - idle gate bit 7 stops counting during processor idle; clear keeps counting.
// - mode bits 6,5,4 enable pair buffering when both modules suit it.
// - counter runs only while software holds control bit 6 set.
// - overflow sets control bit 7; only software clears it, software may set.
// - module events set control bits 0 to 5; only software clears them.
// - one sixteen-bit count is the shared time base for all six modules.
// - modules 0 to 5 each choose capture, timer, fast output, pwm, pwm-match.
// - a module not using its pin leaves that pin free for plain io.
// - software-writable low reload byte loads the counter low byte at overflow.
// - each module irq enable gates whether its flag requests an interrupt.
`ifndef PCABT_MAP_SVH
`define PCABT_MAP_SVH
`define PCABT_ADDR_CTRL 8'hd8
`define PCABT_ADDR_MODE 8'hd9
`define PCABT_ADDR_CNT_LO 8'he9
`define PCABT_ADDR_CNT_HI 8'hf9
`define PCABT_ADDR_RLD_LO 8'hce
`define PCABT_ADDR_RLD_HI 8'hcf
`define PCABT_REG_RESET 8'h00
`define PCABT_CNT_RESET 16'h0000
`define PCABT_CNT_MAX 16'hffff
`define PCABT_CTRL_OVF_BIT 7
`define PCABT_CTRL_RUN_BIT 6
`define PCABT_CTRL_FLAG_MSB 5
`define PCABT_CTRL_FLAG_LSB 0
`define PCABT_BYTE_LO_MSB 7
`define PCABT_BYTE_LO_LSB 0
`define PCABT_BYTE_HI_MSB 15
`define PCABT_BYTE_HI_LSB 8
`define PCABT_GPIO_RESET 6'h3f
`define PCABT_PAIR_RESET 3'h0
`define PCABT_MODE_IDLE_BIT 7
`define PCABT_MODE_BUF4_BIT 6
`define PCABT_MODE_BUF2_BIT 5
`define PCABT_MODE_BUF0_BIT 4
`define PCABT_MODE_SRC_MSB 3
`define PCABT_MODE_SRC_LSB 1
`define PCABT_MODE_OVF_IE_BIT 0
`define PCABT_SRC_DIV12 3'h0
`define PCABT_SRC_DIV2 3'h1
`define PCABT_SRC_TIMER0 3'h2
`define PCABT_SRC_EXT 3'h3
`define PCABT_SRC_FAST 3'h4
`define PCABT_SRC_SYS 3'h5
`define PCABT_SRC_MASTER 3'h7
`define PCABT_DIV12_LAST 4'hb
`define PCABT_DIV_RESET 4'h0
`endif

// [core/pcabt_pkg.sv]
// shared types of the counter array time base
package pcabt_pkg;
   typedef logic [7:0] pcabt_byte_t;
   typedef logic [2:0] pcabt_src_t;
   typedef logic [15:0] pcabt_count_t;
endpackage

// [core/pcabt_if.sv]
// carrier between the time base core and its count pulse generator
`timescale 1ns/1ps
interface pcabt_if;
   pcabt_pkg::pcabt_src_t source_select;
   logic timer0_ovf;
   logic count_tick;
   modport ctl (output source_select, output timer0_ovf, input count_tick);
   modport gen (input source_select, input timer0_ovf, output count_tick);
endinterface

// [core/pcabt_sync.sv]
// three-flop pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module pcabt_sync #(
   parameter int WIDTH = 3
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_d;

   // stage one is read by stage two only
   assign level_d = (stage2_q & stage3_q) | (level_out & (stage2_q ^ stage3_q));

   // shift chain plus agreed level
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         stage1_q <= '1;
         stage2_q <= '1;
         stage3_q <= '1;
         level_out <= '1;
      end
      else
      begin
         stage1_q <= pin_in;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         level_out <= level_d;
      end
   end
endmodule // pcabt_sync

// [core/pcabt_pulse.sv]
// count pulse generator: prescalers, pin edge detection, source selection
`timescale 1ns/1ps
`include "pcabt_map.svh"
module pcabt_pulse (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic external_count_input_in,
   input wire logic fast_mixed_source_in,
   input wire logic master_divider_output_in,
   pcabt_if.gen link
);
   logic [3:0] div12_q;
   logic div2_q;
   logic [2:0] level;
   logic [2:0] level_prev_q;
   logic [2:0] fall;
   logic div12_tick;
   logic div2_tick;
   logic tick_d;

   // pins from outside the clock domain: ext, fast, master
   pcabt_sync #(.WIDTH(3)) u_sync (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .pin_in({master_divider_output_in, fast_mixed_source_in, external_count_input_in}),
      .level_out(level)
   );

   // falling transitions of the agreed levels
   assign fall = level_prev_q & ~level;
   assign div12_tick = (div12_q == `PCABT_DIV12_LAST);
   assign div2_tick = div2_q;

   // source mux; fast sources are sampled, so they must stay below clk/4 here
   always_comb
   begin
      case (link.source_select)
         `PCABT_SRC_DIV12: tick_d = div12_tick;
         `PCABT_SRC_DIV2: tick_d = div2_tick;
         `PCABT_SRC_TIMER0: tick_d = link.timer0_ovf;
         `PCABT_SRC_EXT: tick_d = fall[0];
         `PCABT_SRC_FAST: tick_d = fall[1];
         `PCABT_SRC_SYS: tick_d = 1'b1;
         `PCABT_SRC_MASTER: tick_d = fall[2];
         default: tick_d = 1'b0; // reserved code never counts
      endcase
   end

   assign link.count_tick = tick_d;

   // free-running prescalers and edge history
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         div12_q <= `PCABT_DIV_RESET;
         div2_q <= 1'b0;
         level_prev_q <= '1;
      end
      else
      begin
         div12_q <= div12_tick ? `PCABT_DIV_RESET : div12_q + 4'h1;
         div2_q <= ~div2_q;
         level_prev_q <= level;
      end
   end
endmodule // pcabt_pulse

// [tb/pcabt_top_sva.sv]
// port-level assertion checker for the counter array time base
`timescale 1ns/1ps
module pcabt_sva (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic sfr_wr_in,
   input wire logic toggle_pin_enable_in,
   input wire logic [5:0] module_event_in,
   input wire logic [5:0] module_irq_enable_in,
   input wire logic [5:0] module_buffer_mode_in,
   input wire logic [5:0] module_pin_use_in,
   input wire logic [15:0] count_value_out,
   input wire logic overflow_pulse_out,
   input wire logic overflow_toggle_out,
   input wire logic toggle_pin_oe_out,
   input wire logic [2:0] buffer_pair_active_out,
   input wire logic [5:0] gpio_release_out,
   input wire logic irq_out
);
   // one clock domain; $past guards skip the edge right after reset release
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_step_by_one: assert property (
      $past(reset_n_in) && !$past(sfr_wr_in) && !overflow_pulse_out
      && count_value_out != $past(count_value_out)
      |-> count_value_out == $past(count_value_out) + 16'h0001) else $error("bad count step");
   a_ovf_at_top: assert property (
      overflow_pulse_out |-> $past(count_value_out) == 16'hffff) else $error("overflow not at top");
   a_toggle_flips: assert property (
      overflow_pulse_out |-> overflow_toggle_out != $past(overflow_toggle_out))
      else $error("toggle did not flip");
   a_toggle_holds: assert property (
      !overflow_pulse_out |-> $stable(overflow_toggle_out)) else $error("toggle moved alone");
   a_oe_follows: assert property (
      $past(reset_n_in) |-> toggle_pin_oe_out == $past(toggle_pin_enable_in))
      else $error("pin enable wrong");
   a_gpio_free: assert property (
      $past(reset_n_in) |-> gpio_release_out == ~$past(module_pin_use_in))
      else $error("gpio release wrong");
   a_pair_valid: assert property (
      $past(reset_n_in) |-> (buffer_pair_active_out & ~$past({&module_buffer_mode_in[5:4],
      &module_buffer_mode_in[3:2], &module_buffer_mode_in[1:0]})) == 3'h0)
      else $error("pair active without both modules");
   a_event_irq: assert property (
      (|(module_event_in & module_irq_enable_in)) ##1 $stable(module_irq_enable_in)
      |-> ##1 irq_out) else $error("enabled event gave no irq");
   c_overflow: cover property (overflow_pulse_out);
   c_irq: cover property ($rose(irq_out));
   c_pairs: cover property (buffer_pair_active_out != 3'h0);
endmodule // pcabt_sva

bind pcabt_top pcabt_sva u_sva (.ref_clk_in, .reset_n_in, .sfr_wr_in, .toggle_pin_enable_in,
   .module_event_in, .module_irq_enable_in, .module_buffer_mode_in, .module_pin_use_in,
   .count_value_out, .overflow_pulse_out, .overflow_toggle_out, .toggle_pin_oe_out,
   .buffer_pair_active_out, .gpio_release_out, .irq_out);

// [tb/pcabt_top_tb.sv]
// self-checking bench for the counter array time base
`timescale 1ns/1ps
module pcabt_top_tb;
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00;
   logic [7:0] sfr_wdata_in = 8'h00;
   logic sfr_wr_in = 1'b0;
   logic sfr_rd_in = 1'b0;
   logic idle_mode_in = 1'b0;
   logic timer0_ovf_in = 1'b0;
   logic pin_lvl = 1'b1;
   logic toggle_pin_enable_in = 1'b0;
   logic [5:0] module_event_in = 6'h00;
   logic [5:0] module_irq_enable_in = 6'h00;
   logic [5:0] module_buffer_mode_in = 6'h00;
   logic [5:0] module_pin_use_in = 6'h00;
   logic [7:0] sfr_rdata_out;
   logic [15:0] count_value_out;
   logic overflow_pulse_out, overflow_toggle_out, toggle_pin_out, toggle_pin_oe_out, irq_out;
   logic [2:0] buffer_pair_active_out;
   logic [5:0] gpio_release_out;
   logic [15:0] d;
   logic [15:0] lo [8] = '{16'h0009, 16'h003b, 16'h0005, 16'h0005, 16'h0005, 16'h0076,
      16'h0000, 16'h0005};
   logic [15:0] hi [8] = '{16'h000b, 16'h003f, 16'h0005, 16'h0005, 16'h0005, 16'h007c,
      16'h0000, 16'h0005};
   logic [7:0] addrs [7] = '{8'hd8, 8'hd9, 8'he9, 8'hf9, 8'hce, 8'hcf, 8'h55};
   int n_mismatch = 0;
   int samples_checked = 0;
   int k;

   // one pin level feeds all three sampled sources so each source sees the same edges
   pcabt_top DUT (.ref_clk_in, .reset_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
      .sfr_wdata_in, .idle_mode_in, .timer0_ovf_in, .external_count_input_in(pin_lvl),
      .fast_mixed_source_in(pin_lvl), .master_divider_output_in(pin_lvl), .toggle_pin_enable_in,
      .module_event_in, .module_irq_enable_in, .module_buffer_mode_in, .module_pin_use_in,
      .sfr_rdata_out, .count_value_out, .overflow_pulse_out, .overflow_toggle_out,
      .toggle_pin_out, .toggle_pin_oe_out, .buffer_pair_active_out, .gpio_release_out, .irq_out);

   always #5 ref_clk_in = ~ref_clk_in;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // strobes last one cycle and are launched on the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk_in);
      sfr_addr_in = a;
      sfr_wdata_in = v;
      sfr_wr_in = 1'b1;
      @(negedge ref_clk_in);
      sfr_wr_in = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk_in);
      sfr_addr_in = a;
      sfr_rd_in = 1'b1;
      @(negedge ref_clk_in);
      sfr_rd_in = 1'b0;
      @(negedge ref_clk_in);
      check({8'h00, sfr_rdata_out}, {8'h00, exp});
   endtask

   // run 120 cycles from zero with timer0 pulses and pin falls every 24 cycles
   task automatic measure(input logic [7:0] mode, input logic idle, output logic [15:0] n);
      wr(8'hd9, mode);
      wr(8'he9, 8'h00);
      wr(8'hf9, 8'h00);
      idle_mode_in = idle;
      wr(8'hd8, 8'h40);
      for (int j = 0; j < 120; j++)
      begin
         @(negedge ref_clk_in);
         timer0_ovf_in = (j % 24 == 0);
         // fast sources get slow edges here: the sampled core cannot see a higher rate
         pin_lvl = (j % 24 < 12);
      end
      wr(8'hd8, 8'h00);
      idle_mode_in = 1'b0;
      repeat (6) @(negedge ref_clk_in);
      n = count_value_out;
   endtask

   task automatic results;
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // a hang is cut well beyond the roughly fifteen hundred cycles the sequence needs
   initial
   begin
      #300000;
      n_mismatch++;
      results;
   end

   initial
   begin
      repeat (10) @(negedge ref_clk_in);
      reset_n_in = 1'b1;
      for (int i = 0; i < 7; i++)
         rd(addrs[i], 8'h00);
      module_pin_use_in = 6'h2a;
      rd(8'hd9, 8'h00);
      check({10'h000, gpio_release_out}, 16'h0015);
      check({15'h0000, toggle_pin_oe_out}, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         measure({4'h0, i[2:0], 1'b0}, 1'b0, d);
         check(16'(d >= lo[i] && d <= hi[i]), 16'h0001);
      end
      measure(8'h8a, 1'b1, d);
      check(d, 16'h0000);
      measure(8'h0a, 1'b1, d);
      check(16'(d >= lo[5] && d <= hi[5]), 16'h0001);
      // overflow from fffd with reload 1234 and the overflow irq enabled
      wr(8'hce, 8'h34);
      wr(8'hcf, 8'h12);
      rd(8'hce, 8'h34);
      wr(8'hd9, 8'h0b);
      wr(8'he9, 8'hfd);
      wr(8'hf9, 8'hff);
      wr(8'hd8, 8'h40);
      k = 0;
      while (overflow_pulse_out !== 1'b1 && k < 50)
      begin
         @(posedge ref_clk_in);
         #1;
         k++;
      end
      check(count_value_out, 16'h1234);
      check({15'h0000, overflow_pulse_out}, 16'h0001);
      check({15'h0000, overflow_toggle_out}, 16'h0001);
      repeat (2) @(negedge ref_clk_in);
      check({15'h0000, overflow_pulse_out}, 16'h0000);
      check({15'h0000, irq_out}, 16'h0001);
      rd(8'hd8, 8'hc0);
      wr(8'hd8, 8'h00);
      wr(8'he9, 8'h5a);
      wr(8'hf9, 8'ha5);
      toggle_pin_enable_in = 1'b1;
      repeat (20) @(negedge ref_clk_in);
      check(count_value_out, 16'ha55a);
      check({15'h0000, irq_out}, 16'h0000);
      check({14'h0000, toggle_pin_oe_out, toggle_pin_out}, 16'h0003);
      rd(8'hf9, 8'ha5);
      // software sets the overflow flag; the irq follows the enable bit
      wr(8'hd9, 8'h0a);
      wr(8'hd8, 8'h80);
      rd(8'hd8, 8'h80);
      check({15'h0000, irq_out}, 16'h0000);
      wr(8'hd9, 8'h0b);
      repeat (3) @(negedge ref_clk_in);
      check({15'h0000, irq_out}, 16'h0001);
      wr(8'hd8, 8'h00);
      // module flags: only an enabled flag reaches the irq
      module_irq_enable_in = 6'h01;
      module_event_in = 6'h22;
      @(negedge ref_clk_in);
      module_event_in = 6'h00;
      rd(8'hd8, 8'h22);
      check({15'h0000, irq_out}, 16'h0000);
      module_event_in = 6'h01;
      @(negedge ref_clk_in);
      module_event_in = 6'h00;
      rd(8'hd8, 8'h23);
      check({15'h0000, irq_out}, 16'h0001);
      wr(8'hd8, 8'h00);
      rd(8'hd8, 8'h00);
      check({15'h0000, irq_out}, 16'h0000);
      // buffer pairs need their mode bit and both modules suited
      module_buffer_mode_in = 6'h3e;
      wr(8'hd9, 8'h70);
      rd(8'hd9, 8'h70);
      check({13'h0000, buffer_pair_active_out}, 16'h0006);
      module_buffer_mode_in = 6'h3f;
      wr(8'hd9, 8'h50);
      repeat (3) @(negedge ref_clk_in);
      check({13'h0000, buffer_pair_active_out}, 16'h0005);
      results;
   end
endmodule // pcabt_top_tb
